// ---- tsl_pkg.sv ----
package tsl_pkg;

	// Clock rate
	localparam int CLK_HZ = 100_000_000;

	// Flash half period in ms and cycles
	localparam int FLASH_HALF_MS = 250;
	localparam int FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;

	// Encoder limit: 1 MHz maximum pulse frequency
	localparam int ENC_MAX_HZ = 1_000_000;
	localparam int ENC_MIN_PERIOD_CYC = CLK_HZ / ENC_MAX_HZ;

	// Trigger source select codes
	localparam logic [1:0] TRIG_NONE = 2'h0;
	localparam logic [1:0] TRIG_MFI = 2'h1;
	localparam logic [1:0] TRIG_SYNC = 2'h2;
	localparam logic [1:0] TRIG_ENC = 2'h3;

	// Colour codes on a two-bit {red, green} LED pair
	localparam logic [1:0] LED_OFF = 2'h0;
	localparam logic [1:0] LED_GREEN = 2'h1;
	localparam logic [1:0] LED_RED = 2'h2;
	localparam logic [1:0] LED_YELLOW = 2'h3;

	// Reset values
	localparam logic [31:0] ENC_COUNT_RST = 32'h0000_0000;

endpackage

// ---- tsl_sync2.sv ----
`timescale 1ns/100ps
`default_nettype none

// Two-flop synchroniser for a bundle of pin levels
module tsl_sync2 #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Levels
	input  wire logic [W-1:0] pinIn,
	output logic      [W-1:0] syncOut
);

	// First stage, read only by the second
	logic [W-1:0] meta_q;

	// Two stages in series
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			syncOut <= '0;
		end else begin
			meta_q <= pinIn;
			syncOut <= meta_q;
		end
	end

endmodule

`default_nettype wire

// ---- tsl_trigger_leds.sv ----
`timescale 1ns/100ps
`default_nettype none

// Operation
// RL1 - Dark acquisition flashes intensity and range red
// RL2 - No target or outside: range red
// RL3 - Target near mid: range yellow
// RL4 - Target inside range: range green
// RL5 - Proper operation: module state steady green
// RL6 - Not configured: module state flashes green
// RL7 - Recoverable major fault: module state flashes red
// RL8 - Multifunction input selectable as trigger
// RL9 - Sync pair selectable; source symmetrical
// RL10 - Encoder 1 quadrature selectable as trigger
// RL11 - One encoder: tracks A, B, index
// RL12 - Encoder counted up to 1 MHz
// RL13 - Intensity red saturated, yellow low, green ok
// RL14 - Only selected input triggers recording
module tsl_trigger_leds
	import tsl_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Measurement and device state
	input  wire logic        darkAcq,
	input  wire logic        sigSaturated,
	input  wire logic        sigLow,
	input  wire logic        targetValid,
	input  wire logic        targetMid,
	input  wire logic        devConfigured,
	input  wire logic        majorFault,
	// Trigger configuration
	input  wire logic [1:0]  trigSel,
	// Trigger pins
	input  wire logic        mfiPin,
	input  wire logic        syncPos,
	input  wire logic        syncNeg,
	// Encoder pins
	input  wire logic        enc_track_a_pos,
	input  wire logic        enc_track_a_neg,
	input  wire logic        enc_track_b_pos,
	input  wire logic        enc_track_b_neg,
	input  wire logic        enc_index_pos,
	input  wire logic        enc_index_neg,
	// LEDs as {red, green}
	output logic      [1:0]  intensityLed,
	output logic      [1:0]  rangeLed,
	output logic      [1:0]  module_state_led,
	// Trigger and encoder state
	output logic             trigPulse,
	output logic      [31:0] encCount,
	output logic             encIndexSeen
);

	// Differential receive: level is high when plus exceeds minus
	function automatic logic diffRx(input logic p, input logic n);
		return p & ~n;
	endfunction

	// Raw pin levels, one bit per wire
	logic [8:0] pinRaw;
	logic [8:0] pinRawSync;
	logic [4:0] pinSync;
	assign pinRaw = {enc_index_neg, enc_index_pos, enc_track_b_neg, enc_track_b_pos,
		enc_track_a_neg, enc_track_a_pos, syncNeg, syncPos, mfiPin};

	// Every wire passes two flops before any decoding
	tsl_sync2 #(.W(9)) uSync (
		.clk     (clk),
		.rst_n   (rst_n),
		.pinIn   (pinRaw),
		.syncOut (pinRawSync)
	);

	// Differential levels built from the synchronised wires
	assign pinSync = {diffRx(pinRawSync[7], pinRawSync[8]),
		diffRx(pinRawSync[5], pinRawSync[6]),
		diffRx(pinRawSync[3], pinRawSync[4]),
		diffRx(pinRawSync[1], pinRawSync[2]), pinRawSync[0]};

	// Edge detection held off until the previous-level register holds a real sample,
	// so a pin resting high at reset release gives no false edge or count
	logic [1:0] armCnt_q;
	logic       armed;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			armCnt_q <= 2'h0;
		end else if (!armed) begin
			armCnt_q <= armCnt_q + 2'h1;
		end
	end
	assign armed = &armCnt_q;

	// Previous synchronised levels for edge detection
	logic [4:0] pinPrev_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pinPrev_q <= '0;
		end else begin
			pinPrev_q <= pinSync;
		end
	end

	// Edge terms
	logic mfiRise;
	logic syncRise;
	logic encStep;
	logic encUp;
	logic idxRise;
	assign mfiRise = armed & pinSync[0] & ~pinPrev_q[0];
	assign syncRise = armed & pinSync[1] & ~pinPrev_q[1];
	assign idxRise = armed & pinSync[4] & ~pinPrev_q[4];
	assign encStep = armed & ((pinSync[2] ^ pinPrev_q[2]) | (pinSync[3] ^ pinPrev_q[3]));
	// Direction: A leads B when new A differs from old B
	assign encUp = pinSync[2] ^ pinPrev_q[3];

	// Quadrature counter, one count per edge
	// RL11 encoder tracks decoded
	// RL12 every edge counted
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			encCount <= ENC_COUNT_RST;
		end else if (encStep) begin
			encCount <= encUp ? encCount + 32'h1 : encCount - 32'h1;
		end
	end

	// Index pulse flag, sticky until reset
	// RL11 index input
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			encIndexSeen <= 1'b0;
		end else if (idxRise) begin
			encIndexSeen <= 1'b1;
		end
	end

	// Trigger selection, one source only
	logic trigEvent;
	always_comb begin
		unique case (trigSel)
			// RL8 multifunction source
			TRIG_MFI: trigEvent = mfiRise;
			// RL9 sync pair source
			TRIG_SYNC: trigEvent = syncRise;
			// RL10 encoder motion source
			TRIG_ENC: trigEvent = encStep;
			TRIG_NONE: trigEvent = 1'b0;
		endcase
	end

	// Registered trigger pulse
	// RL14 unselected inputs ignored
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trigPulse <= 1'b0;
		end else begin
			trigPulse <= trigEvent;
		end
	end

	// Flash timebase
	logic [31:0] flashCnt_q;
	logic        flashOn_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flashCnt_q <= '0;
			flashOn_q <= 1'b0;
		end else if (flashCnt_q == 32'(FLASH_HALF_CYC - 1)) begin
			flashCnt_q <= '0;
			flashOn_q <= ~flashOn_q;
		end else begin
			flashCnt_q <= flashCnt_q + 32'h1;
		end
	end

	// Flashing colour helper
	function automatic logic [1:0] flashCol(input logic on, input logic [1:0] col);
		return on ? col : LED_OFF;
	endfunction

	// Intensity LED
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			intensityLed <= LED_OFF;
		end else if (darkAcq) begin
			// RL1 flash red
			intensityLed <= flashCol(flashOn_q, LED_RED);
		end else if (sigSaturated) begin
			// RL13 saturated red
			intensityLed <= LED_RED;
		end else if (sigLow) begin
			intensityLed <= LED_YELLOW;
		end else begin
			intensityLed <= LED_GREEN;
		end
	end

	// Range LED
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rangeLed <= LED_OFF;
		end else if (darkAcq) begin
			// RL1 flash red
			rangeLed <= flashCol(flashOn_q, LED_RED);
		end else if (!targetValid) begin
			// RL2 out of range
			rangeLed <= LED_RED;
		end else if (targetMid) begin
			// RL3 near mid
			rangeLed <= LED_YELLOW;
		end else begin
			// RL4 inside range
			rangeLed <= LED_GREEN;
		end
	end

	// Module state LED
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			module_state_led <= LED_OFF;
		end else if (majorFault) begin
			// RL7 fault flash red
			module_state_led <= flashCol(flashOn_q, LED_RED);
		end else if (!devConfigured) begin
			// RL6 standby flash green
			module_state_led <= flashCol(flashOn_q, LED_GREEN);
		end else begin
			// RL5 steady green
			module_state_led <= LED_GREEN;
		end
	end

	// Assertions
	a_range_out_red: assert property (@(posedge clk) disable iff (!rst_n) // RL2
		(!darkAcq && !targetValid) |=> rangeLed == LED_RED)
		else $error("range LED not red out of range");
	a_range_mid_yel: assert property (@(posedge clk) disable iff (!rst_n) // RL3
		(!darkAcq && targetValid && targetMid) |=> rangeLed == LED_YELLOW)
		else $error("range LED not yellow at mid");
	a_range_in_green: assert property (@(posedge clk) disable iff (!rst_n) // RL4
		(!darkAcq && targetValid && !targetMid) |=> rangeLed == LED_GREEN)
		else $error("range LED not green in range");
	a_dark_no_green: assert property (@(posedge clk) disable iff (!rst_n) // RL1
		darkAcq |=> !intensityLed[0] && !rangeLed[0])
		else $error("green shown during dark acquisition");
	a_ms_ok_green: assert property (@(posedge clk) disable iff (!rst_n) // RL5
		(devConfigured && !majorFault) |=> module_state_led == LED_GREEN)
		else $error("module state not green");
	a_ms_standby: assert property (@(posedge clk) disable iff (!rst_n) // RL6
		(!devConfigured && !majorFault) |=> !module_state_led[1])
		else $error("standby shows red");
	a_ms_fault: assert property (@(posedge clk) disable iff (!rst_n) // RL7
		majorFault |=> !module_state_led[0])
		else $error("fault shows green");
	a_int_sat_red: assert property (@(posedge clk) disable iff (!rst_n) // RL13
		(!darkAcq && sigSaturated) |=> intensityLed == LED_RED)
		else $error("intensity not red when saturated");
	a_trig_mfi: assert property (@(posedge clk) disable iff (!rst_n) // RL8
		(trigSel == TRIG_MFI && mfiRise) |=> trigPulse)
		else $error("multifunction trigger lost");
	a_trig_sync: assert property (@(posedge clk) disable iff (!rst_n) // RL9
		(trigSel == TRIG_SYNC && syncRise) |=> trigPulse)
		else $error("sync trigger lost");
	a_trig_enc: assert property (@(posedge clk) disable iff (!rst_n) // RL10
		(trigSel == TRIG_ENC && encStep) |=> trigPulse)
		else $error("encoder trigger lost");
	a_trig_none: assert property (@(posedge clk) disable iff (!rst_n) // RL14
		(trigSel == TRIG_NONE) |=> !trigPulse)
		else $error("trigger with no source");
	a_enc_count: assert property (@(posedge clk) disable iff (!rst_n) // RL12
		!encStep |=> encCount == $past(encCount))
		else $error("encoder count moved without edge");
	a_enc_index: assert property (@(posedge clk) disable iff (!rst_n) // RL11
		idxRise |=> encIndexSeen)
		else $error("index not flagged");

	// Cover main scenarios
	c_trig_enc: cover property (@(posedge clk) disable iff (!rst_n) trigSel == TRIG_ENC ##1 trigPulse);
	c_dark: cover property (@(posedge clk) disable iff (!rst_n) darkAcq ##1 rangeLed == LED_RED);
	c_fault: cover property (@(posedge clk) disable iff (!rst_n) majorFault ##1 module_state_led == LED_RED);

endmodule

`default_nettype wire

// ---- tsl_src_model.sv ----
`timescale 1ns/100ps
`default_nettype none

// Trigger sources and incremental encoder on the far side
module tsl_src_model (
	// Clock
	input  wire logic clk,
	// Trigger pins
	output logic      mfiPin,
	output logic      syncPos,
	output logic      syncNeg,
	// Encoder pins
	output logic      enc_track_a_pos,
	output logic      enc_track_a_neg,
	output logic      enc_track_b_pos,
	output logic      enc_track_b_neg,
	output logic      enc_index_pos,
	output logic      enc_index_neg
);
	logic a = 1'b0; // Track A level
	logic b = 1'b0; // Track B level
	logic x = 1'b0; // Index level
	logic s = 1'b0; // Sync level
	initial mfiPin = 1'b0;
	assign syncPos = s;
	assign syncNeg = ~s;
	assign enc_track_a_pos = a;
	assign enc_track_a_neg = ~a;
	assign enc_track_b_pos = b;
	assign enc_track_b_neg = ~b;
	assign enc_index_pos = x;
	assign enc_index_neg = ~x;
	// Wait edges, then step off the edge
	task automatic hold(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// edges 25 cycles apart keep 1 MHz
	task automatic quad(input int n, input bit fwd);
		for (int i = 0; i < n; i++) begin
			hold(25);
			if ((a ^ b) ^ fwd) a = ~a;
			else b = ~b;
		end
	endtask
	// Pulse: 0 multifunction, 1 sync, 2 index
	task automatic pulse(input int k, input int w);
		hold(1);
		if (k == 0) mfiPin = 1'b1;
		else if (k == 1) s = 1'b1;
		else x = 1'b1;
		hold(w);
		mfiPin = 1'b0;
		s = 1'b0;
		x = 1'b0;
	endtask
endmodule

`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/100ps
`default_nettype none

module testbench
	import tsl_pkg::*;
;
	logic        clk, rst_n, darkAcq, sigSaturated, sigLow, targetValid;
	logic        targetMid, devConfigured, majorFault, mfiPin, syncPos, syncNeg;
	logic        enc_track_a_pos, enc_track_a_neg, enc_track_b_pos, enc_track_b_neg;
	logic        enc_index_pos, enc_index_neg, trigPulse, encIndexSeen;
	logic [1:0]  trigSel, intensityLed, rangeLed, module_state_led;
	logic [31:0] encCount, c;
	int          error_cnt, checks, pulses;

	tsl_trigger_leds u_tsl_trigger_leds (.clk, .rst_n, .darkAcq, .sigSaturated, .sigLow, .targetValid,
		.targetMid, .devConfigured, .majorFault, .trigSel, .mfiPin, .syncPos, .syncNeg, .enc_track_a_pos,
		.enc_track_a_neg, .enc_track_b_pos, .enc_track_b_neg, .enc_index_pos, .enc_index_neg, .intensityLed,
		.rangeLed, .module_state_led, .trigPulse, .encCount, .encIndexSeen);
	tsl_src_model u_tsl_src_model (.clk, .mfiPin, .syncPos, .syncNeg, .enc_track_a_pos, .enc_track_a_neg,
		.enc_track_b_pos, .enc_track_b_neg, .enc_index_pos, .enc_index_neg);

	// Clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Count trigger pulses
	always @(posedge clk) if (trigPulse === 1'b1) pulses++;
	// Watchdog
	initial begin
		#500_000;
		error_cnt++;
		stop_test();
	end

	// Compare and report
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Set states; flash bits allow off
	task automatic ledCase(input logic [6:0] v, input logic [1:0] ei, er, em, input logic [2:0] f);
		darkAcq = v[6];
		sigSaturated = v[5];
		sigLow = v[4];
		targetValid = v[3];
		targetMid = v[2];
		devConfigured = v[1];
		majorFault = v[0];
		u_tsl_src_model.hold(3);
		chk("intensity", 1, intensityLed === ei || (f[2] && intensityLed === LED_OFF));
		chk("range", 1, rangeLed === er || (f[1] && rangeLed === LED_OFF));
		chk("module", 1, module_state_led === em || (f[0] && module_state_led === LED_OFF));
	endtask
	// Fire every source, count triggers
	task automatic trigCase(input logic [1:0] sel, input int exp);
		trigSel = sel;
		u_tsl_src_model.hold(3);
		pulses = 0;
		u_tsl_src_model.pulse(0, 5000);
		u_tsl_src_model.pulse(1, 20);
		u_tsl_src_model.quad(4, 1);
		u_tsl_src_model.hold(10);
		chk("triggers", exp, pulses);
	endtask
	// Count forward then back, then flag the index
	task automatic encCase();
		c = encCount;
		u_tsl_src_model.quad(8, 1);
		u_tsl_src_model.hold(6);
		chk("count up", c + 32'h8, encCount);
		u_tsl_src_model.quad(3, 0);
		u_tsl_src_model.hold(6);
		chk("count down", c + 32'h5, encCount);
		u_tsl_src_model.pulse(2, 20);
		u_tsl_src_model.hold(6);
		chk("index", 32'h1, 32'(encIndexSeen));
	endtask
	// Mid-run reset with the encoder resting off zero: no false count or trigger
	task automatic resetCase();
		rst_n = 1'b0;
		u_tsl_src_model.hold(2);
		chk("count in reset", 32'h0, encCount);
		chk("index in reset", 32'h0, 32'(encIndexSeen));
		chk("module in reset", 32'(LED_OFF), 32'(module_state_led));
		pulses = 0;
		rst_n = 1'b1;
		u_tsl_src_model.hold(8);
		chk("count after reset", 32'h0, encCount);
		chk("trig after reset", 32'h0, pulses);
	endtask

	// Verdict
	task automatic stop_test();
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// Main sequence
	initial begin
		rst_n = 1'b0;
		trigSel = TRIG_NONE;
		{darkAcq, sigSaturated, sigLow, targetValid, targetMid, devConfigured, majorFault} = 7'h00;
		repeat (5) @(posedge clk);
		#1 rst_n = 1'b1;
		u_tsl_src_model.hold(2);
		chk("count", 32'h0, encCount);
		chk("index", 1'b0, encIndexSeen);
		ledCase(7'h0A, LED_GREEN, LED_GREEN, LED_GREEN, 3'h0);
		ledCase(7'h2E, LED_RED, LED_YELLOW, LED_GREEN, 3'h0);
		ledCase(7'h13, LED_YELLOW, LED_RED, LED_RED, 3'h1);
		ledCase(7'h35, LED_RED, LED_RED, LED_RED, 3'h1);
		ledCase(7'h40, LED_RED, LED_RED, LED_GREEN, 3'h7);
		trigCase(TRIG_NONE, 0);
		trigCase(TRIG_MFI, 1);
		trigCase(TRIG_SYNC, 1);
		trigCase(TRIG_ENC, 4);
		encCase();
		resetCase();
		ledCase(7'h0A, LED_GREEN, LED_GREEN, LED_GREEN, 3'h0);
		stop_test();
	end
endmodule

`default_nettype wire
